// >>> rpsc_chain.sv
// Register preload scan chain for the output macrocell registers
`timescale 1ns/10ps
// Summary of operation
// - Preload active only while select input held
// - Only registered macrocells form chain stages
// - Each rising shift clock edge advances chain, except edges seen while the read-back buffer is full
// - Serial data enters lowest pin, moves upward
// - First bit shifted ends in highest pin
// - Old contents shift out on serial output
// - Readback ignores the output enable state
// - Low bit means reset, high means set
// - Output pins show register state inverted
// - Any state loadable at any test point
// - Normal clocking resumes from loaded state
// - Power-up clears all macrocell registers low
// - Power-up reset lasts 45 microseconds maximum
module rpsc_chain #(
    parameter int NUM_CELLS = rpsc_pkg::NUM_CELLS,
    parameter int POWER_UP_RESET_CYCLES = rpsc_pkg::POWER_UP_RESET_CYCLES
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic preload_mode_select, // High while elevated select level seen
    input wire logic preload_shift_clock, // Shift clock, sampled
    input wire logic serial_preload_in, // Serial data into lowest pin cell
    input wire logic func_clk_en, // Functional register clock pulse
    input wire logic [NUM_CELLS-1:0] array_next_state, // Next state from logic array
    input wire logic [NUM_CELLS-1:0] registered_cfg, // 1 where cell is registered
    input wire logic output_enable_n, // Registered output enable, low active
    output logic serial_state_out, // Serial state, open drain data
    output logic serial_state_out_oe_n, // Low while pin pulled low
    output logic serial_out_valid, // Buffered serial bit is available
    input wire logic serial_out_ready, // Receiver accepts buffered bit
    output logic [NUM_CELLS-1:0] output_pin_n, // Active-low pin levels
    output logic [NUM_CELLS-1:0] output_pin_oe_n, // Low while pin driven
    output logic [NUM_CELLS-1:0] reg_state, // Register state for observation
    output logic reset_done // Power-up reset complete
);
    rpsc_pkg::rpsc_state_e state_q, state_d;
    logic [rpsc_pkg::RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
    logic [NUM_CELLS-1:0] regs_q, regs_d;
    logic sclk_prev_q, sclk_prev_d;
    logic reset_done_q, reset_done_d;
    rpsc_pkg::rpsc_bit_s buf_mem_q [2];
    rpsc_pkg::rpsc_bit_s buf_mem_d [2];
    logic [1:0] buf_cnt_q, buf_cnt_d;
    logic [NUM_CELLS-1:0] pins_n_q, pins_n_d, pins_oe_n_q, pins_oe_n_d;
    logic sout_q, sout_d, sout_oe_n_q, sout_oe_n_d;
    logic shift_edge, top_bit, carry, push, pop, buf_ready;

    // Top of chain: highest registered pin, or the input if none registered
    always_comb begin
        top_bit = serial_preload_in;
        for (int i = 0; i < NUM_CELLS; i++) begin
            if (registered_cfg[i]) begin
                top_bit = regs_q[i];
            end
        end
    end

    assign buf_ready = (buf_cnt_q != 2'd2);
    // A full buffer drops the shift edge, with no later retry, so no read-back bit is lost
    // Select must still be high, or a bit is pushed on the exit cycle with no shift
    assign shift_edge = (state_q == rpsc_pkg::RPSC_ST_PRELOAD) && preload_mode_select
                        && preload_shift_clock && !sclk_prev_q && buf_ready;
    assign push = shift_edge;
    assign pop = (buf_cnt_q != 2'd0) && serial_out_ready;

    always_comb begin
        state_d = state_q;
        rst_cnt_d = rst_cnt_q;
        reset_done_d = reset_done_q;
        regs_d = regs_q;
        sclk_prev_d = preload_shift_clock;
        carry = serial_preload_in;
        case (state_q)
            rpsc_pkg::RPSC_ST_POWER_UP: begin
                regs_d = rpsc_pkg::REG_RESET_VALUE;
                if (rst_cnt_q == rpsc_pkg::RST_CNT_W'(POWER_UP_RESET_CYCLES - 1)) begin
                    state_d = rpsc_pkg::RPSC_ST_NORMAL;
                    reset_done_d = 1'b1;
                end else begin
                    rst_cnt_d = rst_cnt_q + 1'b1;
                end
            end
            rpsc_pkg::RPSC_ST_NORMAL: begin
                if (preload_mode_select) begin
                    state_d = rpsc_pkg::RPSC_ST_PRELOAD;
                end else if (func_clk_en) begin
                    for (int i = 0; i < NUM_CELLS; i++) begin
                        if (registered_cfg[i]) begin
                            regs_d[i] = array_next_state[i];
                        end
                    end
                end
            end
            rpsc_pkg::RPSC_ST_PRELOAD: begin
                if (!preload_mode_select) begin
                    state_d = rpsc_pkg::RPSC_ST_NORMAL;
                end else if (shift_edge) begin
                    // Combinatorial cells are bypassed; carry runs upward by pin
                    for (int i = 0; i < NUM_CELLS; i++) begin
                        if (registered_cfg[i]) begin
                            regs_d[i] = carry;
                            carry = regs_q[i];
                        end
                    end
                end
            end
            default: begin
                state_d = rpsc_pkg::RPSC_ST_POWER_UP;
            end
        endcase
    end

    // Two-entry buffer for read-back bits
    always_comb begin
        buf_mem_d = buf_mem_q;
        buf_cnt_d = buf_cnt_q;
        if (pop) begin
            buf_mem_d[0] = buf_mem_q[1];
        end
        if (push) begin
            buf_mem_d[(pop ? buf_cnt_q - 2'd1 : buf_cnt_q) == 2'd0 ? 0 : 1] = '{top_bit};
        end
        buf_cnt_d = buf_cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_comb begin
        sout_d = buf_cnt_d != 2'd0 ? buf_mem_d[0].bit_value : 1'b1;
        // Open drain: drive only when bit is low; tristate gate plays no part
        sout_oe_n_d = !(buf_cnt_d != 2'd0 && !buf_mem_d[0].bit_value);
        pins_n_d = ~regs_d;
        pins_oe_n_d = {NUM_CELLS{output_enable_n}} | ~registered_cfg
                      | {NUM_CELLS{state_d == rpsc_pkg::RPSC_ST_PRELOAD}};
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= rpsc_pkg::RPSC_ST_POWER_UP;
            rst_cnt_q <= '0;
            reset_done_q <= 1'b0;
            regs_q <= rpsc_pkg::REG_RESET_VALUE;
            sclk_prev_q <= 1'b0;
            buf_mem_q[0] <= '0;
            buf_mem_q[1] <= '0;
            buf_cnt_q <= 2'd0;
            sout_q <= 1'b1;
            sout_oe_n_q <= 1'b1;
            pins_n_q <= '1;
            pins_oe_n_q <= '1;
        end else begin
            state_q <= state_d;
            rst_cnt_q <= rst_cnt_d;
            reset_done_q <= reset_done_d;
            regs_q <= regs_d;
            sclk_prev_q <= sclk_prev_d;
            buf_mem_q <= buf_mem_d;
            buf_cnt_q <= buf_cnt_d;
            sout_q <= sout_d;
            sout_oe_n_q <= sout_oe_n_d;
            pins_n_q <= pins_n_d;
            pins_oe_n_q <= pins_oe_n_d;
        end
    end

    // Valid mirrors the count register in the same cycle, with the data it belongs to
    logic valid_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= buf_cnt_d != 2'd0;
        end
    end

    assign serial_state_out = sout_q;
    assign serial_state_out_oe_n = sout_oe_n_q;
    assign serial_out_valid = valid_q;
    assign output_pin_n = pins_n_q;
    assign output_pin_oe_n = pins_oe_n_q;
    assign reg_state = regs_q;
    assign reset_done = reset_done_q;
endmodule : rpsc_chain

// >>> rpsc_pkg.sv
// Package for the register preload scan chain: constants and carriers
package rpsc_pkg;
    localparam int NUM_CELLS = 8;
    // Power-up register reset time in microseconds
    localparam int POWER_UP_RESET_TIME_US = 45;
    localparam int CLK_MHZ = 25;
    // Longest wait, rounded down to whole cycles
    localparam int POWER_UP_RESET_CYCLES = POWER_UP_RESET_TIME_US * CLK_MHZ;
    localparam int RST_CNT_W = 11;
    localparam logic [NUM_CELLS-1:0] REG_RESET_VALUE = 8'h00;

    typedef enum logic [1:0] {
        RPSC_ST_POWER_UP = 2'b00,
        RPSC_ST_NORMAL = 2'b01,
        RPSC_ST_PRELOAD = 2'b10
    } rpsc_state_e;

    // One serial chain bit travelling through the output buffer
    typedef struct packed {
        logic bit_value;
    } rpsc_bit_s;
endpackage : rpsc_pkg

// >>> rpsc_chain_props.sv
// Port assertions for the preload scan chain
`timescale 1ns/10ps
module rpsc_chain_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic preload_mode_select,
    input wire logic preload_shift_clock,
    input wire logic func_clk_en,
    input wire logic serial_state_out,
    input wire logic serial_state_out_oe_n,
    input wire logic serial_out_valid,
    input wire logic serial_out_ready,
    input wire logic [7:0] output_pin_n,
    input wire logic [7:0] reg_state,
    input wire logic reset_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_preload; (reset_done && preload_mode_select) [*3]; endsequence
    sequence s_shift_edge; !preload_shift_clock ##1 preload_shift_clock; endsequence
    property p_clear; $fell(rst) |-> reg_state == 8'h00 && output_pin_n == 8'hff; endproperty
    a_clear: assert property (p_clear) else $error("regs not clear");
    property p_done; $fell(rst) |-> (!reset_done) [*3]; endproperty
    a_done: assert property (p_done) else $error("done early");
    property p_inv; $stable(reg_state) |-> output_pin_n == ~reg_state; endproperty
    a_inv: assert property (p_inv) else $error("pins");
    property p_drain; serial_state_out_oe_n == (serial_state_out || !serial_out_valid); endproperty
    a_drain: assert property (p_drain) else $error("open drain");
    property p_push;
        $rose(serial_out_valid) |-> $past(preload_shift_clock) && !$past(preload_shift_clock, 2);
    endproperty
    a_push: assert property (p_push) else $error("push");
    property p_gate; (!preload_mode_select) [*4] |-> !$rose(serial_out_valid); endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_hold; s_preload ##0 (func_clk_en && !preload_shift_clock) |=> $stable(reg_state);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_stand; serial_out_valid && !serial_out_ready |=> $stable(serial_state_out);
    endproperty
    a_stand: assert property (p_stand) else $error("stand");
endmodule : rpsc_chain_props
bind rpsc_chain rpsc_chain_props u_props (.*);

// >>> rpsc_tester.sv
// Tester model: preload select, shift clock, serial data and read-back
`timescale 1ns/10ps
module rpsc_tester (
    input wire logic core_clk, // Bench clock
    input wire logic serial_line, // Pulled-up read-back line
    input wire logic serial_out_valid, // Read-back bit waiting
    output logic preload_mode_select, // Select level
    output logic preload_shift_clock, // Shift clock
    output logic serial_preload_in, // Serial data
    output logic serial_out_ready // Read-back accept
);
    initial {preload_mode_select, preload_shift_clock, serial_preload_in, serial_out_ready} = '0;
    task automatic set_mode(input logic m);
        @(negedge core_clk);
        preload_mode_select = m;
        repeat (2) @(negedge core_clk);
    endtask : set_mode
    task automatic shift_bit(input logic b, input logic [1:0] stall, output logic got);
        @(negedge core_clk);
        serial_preload_in = b;
        preload_shift_clock = 1'b1;
        @(negedge core_clk);
        preload_shift_clock = 1'b0;
        // Data is no longer held, so show the inverse rather than a stale level
        serial_preload_in = ~b;
        repeat (stall) @(negedge core_clk);
        serial_out_ready = 1'b1;
        // Sample at the falling edge where the bit is settled; the next rising edge pops it
        while (!serial_out_valid) @(negedge core_clk);
        got = serial_line;
        @(negedge core_clk);
        serial_out_ready = 1'b0;
    endtask : shift_bit
endmodule : rpsc_tester

// >>> rpsc_chain_tb.sv
// Self-checking bench for the preload scan chain
`timescale 1ns/10ps
module rpsc_chain_tb;
    logic core_clk = 1'b0, rst = 1'b1, func_clk_en = 1'b0, output_enable_n = 1'b0, got, eb;
    logic [7:0] array_next_state = 8'h00, registered_cfg = 8'hff, exp_q;
    logic [31:0] seed = 32'h0000_db19;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    wire preload_mode_select, preload_shift_clock, serial_preload_in, serial_out_ready;
    wire serial_state_out, serial_state_out_oe_n, serial_out_valid, reset_done;
    wire [7:0] output_pin_n, output_pin_oe_n, reg_state;
    // Pull-up: the line is low only while the chain pulls it down
    wire serial_line = serial_state_out_oe_n;
    rpsc_chain #(.POWER_UP_RESET_CYCLES(4)) DUT (.*);
    rpsc_tester TST (.*);
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cycles > 3000) begin
        miscompares++;
        end_sim();
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [8:0] shf(logic [7:0] s, logic [7:0] c, logic b);
        for (int i = 0; i < 8; i++) if (c[i]) {b, s[i]} = {s[i], b};
        return {b, s};
    endfunction : shf
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic pulse_func();
        @(negedge core_clk);
        func_clk_en = 1'b1;
        @(negedge core_clk);
        func_clk_en = 1'b0;
    endtask : pulse_func
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        chk(output_pin_n & ~reg_state, 8'hff);
        while (reset_done !== 1'b1) @(negedge core_clk);
        for (int t = 0; t < 8; t++) begin
            registered_cfg = t == 0 ? 8'hff : t == 1 ? 8'h01 : 8'(rnd()) | 8'h80;
            array_next_state = 8'(rnd());
            pulse_func();
            exp_q = array_next_state & registered_cfg;
            chk(reg_state & registered_cfg, exp_q);
            output_enable_n = t[0];
            TST.set_mode(1'b1);
            for (int n = 0; n < 8; n++) begin
                {eb, exp_q} = shf(exp_q, registered_cfg, seed[5]);
                TST.shift_bit(seed[5], seed[2:1], got);
                chk(8'(got), 8'(eb));
                void'(rnd());
            end
            pulse_func();
            chk(reg_state & registered_cfg, exp_q);
            chk(output_pin_oe_n, 8'hff);
            TST.set_mode(1'b0);
            chk(output_pin_oe_n, {8{output_enable_n}} | ~registered_cfg);
            output_enable_n = 1'b0;
            chk(output_pin_n | ~registered_cfg, ~exp_q);
        end
        end_sim();
    end
endmodule : rpsc_chain_tb
